// >>> ssp_pkg.sv
// constants, register map and carrier types of the serial port host controller
// assumes a 100 MHz system clock and an AXI4-Lite master on the register side
`default_nettype none
package ssp_pkg;
	// system clock period, used to turn times into cycles
	localparam int SYS_CLK_NS = 10;
	// fastest clock that the port accepts as slave is its cpu clock over two
	localparam int MIN_SCK_HALF_NS = 10;
	localparam logic [7:0] HALF_DIV_MIN = 8'((MIN_SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
	// register byte offsets, one aligned word each
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_STATUS = 6'h04;
	localparam logic [5:0] OFF_TX = 6'h08;
	localparam logic [5:0] OFF_RX = 6'h0c;
	localparam logic [5:0] OFF_GAP = 6'h10;
	// status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_COLL = 2;
	// reset values: half period of four cycles gives an 80 ns clock
	localparam logic [15:0] CTRL_RESET = 16'h0400;
	localparam logic [15:0] GAP_RESET = 16'h0010;
	// a byte is sixteen clock edges, numbered 0 to 15
	localparam logic [4:0] LAST_EDGE = 5'h0f;
	localparam logic [4:0] EDGE_ZERO = 5'h00;
	localparam logic [4:0] EDGE_ONE = 5'h01;
	localparam logic [15:0] GAP_ONE = 16'h0001;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control word as software sees it in the low half of the ctrl register
	typedef struct packed {
		logic [7:0] half_div;
		logic [2:0] spare;
		logic ss_hold;
		logic cpha;
		logic cpol;
		logic role_master;
		logic enable;
	} ssp_ctrl_s;
	// synchronised pin levels
	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
	} ssp_pins_s;
	// engine states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SELECT = 5'h02,
		ST_RUN = 5'h04,
		ST_GAP = 5'h08,
		ST_LISTEN = 5'h10
	} ssp_state_e;
endpackage
`default_nettype wire

// >>> ssp_sync.sv
// two flip-flop synchroniser for pin levels
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
	parameter int W = 3
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// first stage, read only by the second
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// next values
	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	// registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule
`default_nettype wire

// >>> ssp_tick.sv
// half-period divider: one-cycle enable pulse every half_div cycles while run
// assumes half_div below the minimum is clamped here
`timescale 1ns/1ps
`default_nettype none
module ssp_tick (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [7:0] half_div,
	output logic tick
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic next_tick;
	logic [7:0] limit;

	// count up to the limit, restart whenever run drops
	always_comb begin
		limit = (half_div < ssp_pkg::HALF_DIV_MIN) ? ssp_pkg::HALF_DIV_MIN : half_div;
		next_cnt = cnt + 8'h01;
		next_tick = 1'b0;
		if (!run) begin
			next_cnt = 8'h00;
		end else if (next_cnt >= limit) begin
			next_cnt = 8'h00;
			next_tick = 1'b1;
		end
	end

	// registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule
`default_nettype wire

// >>> ssp_host.sv
// host-side partner of a serial peripheral port: external master or slave on its pins
// assumes an AXI4-Lite master on sys_clk; pins are asynchronous and are synchronised here
//
// Overview of operation
// RL1: full duplex, shared clock, msb first
// RL2: port master offers six rates, fastest cpu/4
// RL3: drive port-slave clock no faster than cpu/2
// RL4: port picks select from software or pin
// RL5: hold select pin high while port is master
// RL6: phase one: select low for whole transmission
// RL7: phase zero: select low per byte, high between
// RL8: port drives clock as master, receives as slave
// RL9: port master setup order is software's duty
// RL10: port master bits stay only while select high
// RL11: port master data write starts shifting
// RL12: port sets done flag after each byte
// RL13: master done flag clears status then read
// RL14: slave done flag clears status then access
// RL15: port ignores data writes while done set
// RL16: port slave shifts only on supplied clock
// RL17: port slave setup matches our mode
// RL18: leave a gap so port clears flag
// RL19: same polarity and phase on both ends
// RL20: phase one second edge, phase zero first
// RL21: clock idles at the polarity level
// RL22: polarity change only while port disabled
// RL23: port discards data write during transfer
// RL24: port flags overrun on unserviced byte
// RL25: count sixteen clock edges, eight captures
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe,
	output logic ss_o,
	output logic ss_oe
);
	// merge a write into a stored word under byte strobes
	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// true for any offset that the map holds
	function automatic logic addr_mapped(input logic [5:0] a);
		return (a == ssp_pkg::OFF_CTRL) || (a == ssp_pkg::OFF_STATUS) ||
			(a == ssp_pkg::OFF_TX) || (a == ssp_pkg::OFF_RX) || (a == ssp_pkg::OFF_GAP);
	endfunction

	// synchronised pins and the tick from the divider
	ssp_pkg::ssp_pins_s pin_s;
	logic tick;
	logic tick_run;

	// bus state
	logic aw_hold, next_aw_hold;
	logic [5:0] aw_addr, next_aw_addr;
	logic w_hold, next_w_hold;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	ssp_pkg::ssp_ctrl_s ctrl, next_ctrl;
	logic [15:0] gap_len, next_gap_len;
	// one-cycle requests from the bus to the engine
	logic tx_wr;
	logic [7:0] tx_byte;
	logic [1:0] st_clr;

	// engine state
	ssp_pkg::ssp_state_e state, next_state;
	logic [7:0] sh_out, next_sh_out;
	logic [7:0] sh_in, next_sh_in;
	logic [4:0] edge_cnt, next_edge_cnt;
	logic out_bit, next_out_bit;
	logic sck_r, next_sck_r;
	logic sck_d, next_sck_d;
	logic ss_r, next_ss_r;
	logic [7:0] rx_data, next_rx_data;
	logic done_flag, next_done_flag;
	logic coll_flag, next_coll_flag;
	logic [15:0] gap_cnt, next_gap_cnt;
	logic next_sck_oe, next_mosi_oe, next_miso_oe;
	// engine scratch
	logic edge_hit;
	logic capture;
	logic in_bit;
	logic keep_sel;

	ssp_sync #(.W(3)) u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.d({sck_i, mosi_i, miso_i}),
		.q(pin_s)
	);

	// divider runs only while we make the clock
	assign tick_run = (state == ssp_pkg::ST_SELECT) || (state == ssp_pkg::ST_RUN);

	ssp_tick u_tick (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.run(tick_run),
		.half_div(ctrl.half_div),
		.tick(tick)
	);

	// bus slave: address and data taken in either order, answer after both
	always_comb begin
		next_aw_hold = aw_hold;
		next_aw_addr = aw_addr;
		next_w_hold = w_hold;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		// read slot opens again once no answer is pending
		next_arready = s_axi_arready || !s_axi_rvalid;
		next_ctrl = ctrl;
		next_gap_len = gap_len;
		tx_wr = 1'b0;
		tx_byte = w_data[7:0];
		st_clr = 2'b00;
		// capture each channel on its own handshake
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		// response retires on bready
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// perform the write once both halves are held
		if (aw_hold && w_hold && !s_axi_bvalid) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = addr_mapped(aw_addr) ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
			unique case (aw_addr)
				ssp_pkg::OFF_CTRL: begin
					next_ctrl = 16'(merge_strb({16'h0000, ctrl}, w_data, w_strb));
				end
				ssp_pkg::OFF_STATUS: begin
					// write one to clear done and collision
					if (w_strb[0]) begin
						st_clr = w_data[ssp_pkg::ST_COLL:ssp_pkg::ST_DONE];
					end
				end
				ssp_pkg::OFF_TX: begin
					tx_wr = w_strb[0];
				end
				ssp_pkg::OFF_GAP: begin
					next_gap_len = 16'(merge_strb({16'h0000, gap_len}, w_data, w_strb));
				end
				default: begin
					// read-only or unmapped: no effect
				end
			endcase
		end
		// read channel: one read at a time
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = addr_mapped(s_axi_araddr) ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				ssp_pkg::OFF_CTRL: next_rdata = {16'h0000, ctrl};
				ssp_pkg::OFF_STATUS: next_rdata = {29'h00000000, coll_flag, done_flag,
					state != ssp_pkg::ST_IDLE};
				ssp_pkg::OFF_RX: next_rdata = {24'h000000, rx_data};
				ssp_pkg::OFF_GAP: next_rdata = {16'h0000, gap_len};
				default: next_rdata = 32'h00000000;
			endcase
		end
		// ready only while the holding slot is free
		next_awready = !next_aw_hold;
		next_wready = !next_w_hold;
	end

	// bus registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			aw_hold <= 1'b0;
			aw_addr <= 6'h00;
			w_hold <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ssp_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= ssp_pkg::RESP_OKAY;
			ctrl <= ssp_pkg::CTRL_RESET;
			gap_len <= ssp_pkg::GAP_RESET;
		end else begin
			aw_hold <= next_aw_hold;
			aw_addr <= next_aw_addr;
			w_hold <= next_w_hold;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			ctrl <= next_ctrl;
			gap_len <= next_gap_len;
		end
	end

	// transfer engine: one byte per software write to tx
	always_comb begin
		next_state = state;
		next_sh_out = sh_out;
		next_sh_in = sh_in;
		next_edge_cnt = edge_cnt;
		next_out_bit = out_bit;
		next_sck_r = sck_r;
		next_sck_d = pin_s.sck;
		next_ss_r = ss_r;
		next_rx_data = rx_data;
		next_done_flag = done_flag;
		next_coll_flag = coll_flag;
		next_gap_cnt = gap_cnt;
		edge_hit = 1'b0;
		// phase zero captures on even (leading) edges, phase one on odd
		capture = (edge_cnt[0] == ctrl.cpha); // RL20 RL19 RL17
		in_bit = ctrl.role_master ? pin_s.miso : pin_s.mosi;
		// select may stay low across bytes only with phase one
		keep_sel = ctrl.ss_hold && ctrl.cpha && ctrl.enable && ctrl.role_master; // RL6
		// software clears first so that a same-cycle set wins
		if (st_clr[0]) begin
			next_done_flag = 1'b0;
		end
		if (st_clr[1]) begin
			next_coll_flag = 1'b0;
		end
		unique case (state)
			ssp_pkg::ST_IDLE: begin
				next_sck_r = ctrl.cpol; // RL21
				if (!keep_sel) begin
					next_ss_r = 1'b1; // RL5 RL7
				end
				if (tx_wr && ctrl.enable) begin
					next_edge_cnt = ssp_pkg::EDGE_ZERO;
					// phase zero puts the msb out before the first edge
					next_out_bit = ctrl.cpha ? out_bit : tx_byte[7]; // RL1
					next_sh_out = ctrl.cpha ? tx_byte : {tx_byte[6:0], 1'b0};
					if (ctrl.role_master) begin
						next_ss_r = 1'b0; // RL7
						next_state = ssp_pkg::ST_SELECT;
					end else begin
						// wait for the port's own clock
						next_state = ssp_pkg::ST_LISTEN; // RL8 RL11
					end
				end
			end
			ssp_pkg::ST_SELECT: begin
				// one half period of setup after select falls
				if (tick) begin
					next_state = ssp_pkg::ST_RUN;
				end
			end
			ssp_pkg::ST_RUN: begin
				if (tick) begin
					next_sck_r = !sck_r; // RL3
					edge_hit = 1'b1;
				end
			end
			ssp_pkg::ST_GAP: begin
				// select rises a cycle after the last edge, never with it
				if (!keep_sel) begin
					next_ss_r = 1'b1; // RL6 RL7
				end
				// spacing lets software on the port clear its flags
				if (gap_cnt <= ssp_pkg::GAP_ONE) begin
					next_state = ssp_pkg::ST_IDLE; // RL18
				end else begin
					next_gap_cnt = gap_cnt - ssp_pkg::GAP_ONE;
				end
			end
			ssp_pkg::ST_LISTEN: begin
				// any change of the synchronised clock is one edge
				if (pin_s.sck != sck_d) begin
					edge_hit = 1'b1; // RL8
				end
			end
		endcase
		if (edge_hit) begin
			if (capture) begin
				next_sh_in = {sh_in[6:0], in_bit}; // RL1
			end else begin
				next_out_bit = sh_out[7];
				next_sh_out = {sh_out[6:0], 1'b0};
			end
			next_edge_cnt = edge_cnt + ssp_pkg::EDGE_ONE; // RL25
			if (edge_cnt == ssp_pkg::LAST_EDGE) begin
				next_rx_data = capture ? {sh_in[6:0], in_bit} : sh_in; // RL25
				next_done_flag = 1'b1;
				next_gap_cnt = gap_len;
				next_state = ctrl.role_master ? ssp_pkg::ST_GAP : ssp_pkg::ST_IDLE;
			end
		end
		// a write while busy is dropped and flagged
		if (tx_wr && (state != ssp_pkg::ST_IDLE || !ctrl.enable)) begin
			next_coll_flag = 1'b1;
		end
		// disabling aborts at once and parks the pins
		if (!ctrl.enable) begin
			next_state = ssp_pkg::ST_IDLE;
			next_ss_r = 1'b1; // RL5 RL9
			next_sck_r = ctrl.cpol; // RL21 RL22
		end
		// pin drivers follow the role
		next_sck_oe = ctrl.enable && ctrl.role_master; // RL8
		next_mosi_oe = ctrl.enable && ctrl.role_master;
		next_miso_oe = ctrl.enable && !ctrl.role_master;
	end

	// engine registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= ssp_pkg::ST_IDLE;
			sh_out <= 8'h00;
			sh_in <= 8'h00;
			edge_cnt <= 5'h00;
			out_bit <= 1'b0;
			sck_r <= 1'b0;
			sck_d <= 1'b0;
			ss_r <= 1'b1;
			rx_data <= 8'h00;
			done_flag <= 1'b0;
			coll_flag <= 1'b0;
			gap_cnt <= 16'h0000;
			sck_oe <= 1'b0;
			mosi_oe <= 1'b0;
			miso_oe <= 1'b0;
			ss_oe <= 1'b1;
		end else begin
			state <= next_state;
			sh_out <= next_sh_out;
			sh_in <= next_sh_in;
			edge_cnt <= next_edge_cnt;
			out_bit <= next_out_bit;
			sck_r <= next_sck_r;
			sck_d <= next_sck_d;
			ss_r <= next_ss_r;
			rx_data <= next_rx_data;
			done_flag <= next_done_flag;
			coll_flag <= next_coll_flag;
			gap_cnt <= next_gap_cnt;
			sck_oe <= next_sck_oe;
			mosi_oe <= next_mosi_oe;
			miso_oe <= next_miso_oe;
			ss_oe <= 1'b1;
		end
	end

	// pin levels straight from registers
	assign sck_o = sck_r;
	assign mosi_o = out_bit;
	assign miso_o = out_bit;
	assign ss_o = ss_r;
endmodule
`default_nettype wire

// >>> ssp_host_note_end.sv
// empty compile unit: holds no module
// assumes nothing of its surroundings
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> ssp_host_asserts.sv
// assertions on the host controller pins and bus answers
// assumes it is bound into ssp_host and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module ssp_host_asserts (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic mosi_o,
	input wire logic mosi_oe,
	input wire logic miso_oe,
	input wire logic ss_o,
	input wire logic ss_oe
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	logic [4:0] edge_cnt; // driven clock edges inside this select
	logic [4:0] next_edge_cnt;
	logic sck_prev; // clock level one cycle ago
	// counted from the pin itself, so a divider slip shows in the total
	always_comb begin
		next_edge_cnt = edge_cnt;
		if (ss_o) begin
			next_edge_cnt = 5'h00; // deselected: start again
		end else if (sck_oe && sck_o != sck_prev) begin
			next_edge_cnt = edge_cnt + 5'h01;
		end
	end
	// registers only
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			edge_cnt <= 5'h00;
			sck_prev <= 1'b0;
		end else begin
			edge_cnt <= next_edge_cnt;
			sck_prev <= sck_o;
		end
	end
	a_select_driven: assert property (ss_oe)
		else $error("select pin left undriven");
	a_slave_role_quiet: assert property (miso_oe |-> ss_o && !mosi_oe && !sck_oe)
		else $error("select low or clock driven while port is master");
	a_clock_with_data: assert property (sck_oe == mosi_oe)
		else $error("clock and data drivers disagree");
	a_clock_still_idle: assert property (ss_o && $past(ss_o) && sck_oe && $past(sck_oe)
		|-> $stable(sck_o))
		else $error("clock moved between frames");
	a_no_edge_at_select: assert property ($fell(ss_o) |-> $stable(sck_o))
		else $error("clock edge together with select");
	a_sixteen_edges: assert property ($rose(ss_o) && sck_oe
		|-> edge_cnt + 5'($changed(sck_o)) == 5'h10)
		else $error("byte did not carry sixteen clock edges");
	a_data_on_edge: assert property (sck_oe && !ss_o && !$past(ss_o) && $changed(mosi_o)
		|-> $changed(sck_o))
		else $error("data changed away from a clock edge");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before ready");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before ready");
endmodule
bind ssp_host ssp_host_asserts u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
	.miso_oe(miso_oe), .ss_o(ss_o), .ss_oe(ss_oe));
`default_nettype wire

// >>> ssp_port_model.sv
// behavioural serial port device on the far side of the host controller
// assumes the bench resolves the shared lines and sets the mode between frames
`timescale 1ns/1ps
`default_nettype none
module ssp_port_model #(
	parameter int HALF_NS = 40
) (
	input wire logic is_master,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] tx_byte,
	input wire logic go,
	input wire logic ss_n,
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic sck_drv,
	output logic mosi_out,
	output logic mosi_drv,
	output logic miso_out,
	output logic miso_drv,
	output logic busy,
	output logic [7:0] rx_byte
);
	logic [7:0] sh; // shift register, msb leaves first
	logic sck_r; // clock level inside a frame
	int cnt; // capture edges of this byte
	logic lead; // edge leaves the idle level
	logic flag; // byte done, not yet serviced by the port software
	logic overrun_flag; // a byte ended while flag was still set
	assign sck_out = busy ? sck_r : cpol;
	assign sck_drv = is_master;
	assign mosi_drv = is_master && busy;
	assign miso_drv = !is_master && !ss_n;
	initial begin
		busy = 1'b0;
		sck_r = 1'b0;
		rx_byte = 8'h00;
		mosi_out = 1'b0;
		miso_out = 1'b0;
		flag = 1'b0;
		overrun_flag = 1'b0;
	end
	// end of byte: with the flag still set the new byte is lost
	task automatic end_byte();
		if (flag) overrun_flag = 1'b1;
		else rx_byte = sh;
		flag = 1'b1;
	endtask
	// slave: load on select, shift only on the supplied clock
	always @(negedge ss_n) begin
		if (!is_master) begin
			flag = 1'b0;
			sh = tx_byte;
			cnt = 0;
			if (!cpha) miso_out = sh[7];
		end
	end
	always @(sck_in) begin
		if (!is_master && !ss_n) begin
			lead = (sck_in != cpol);
			if (lead ^ cpha) begin
				sh = {sh[6:0], mosi_in};
				cnt++;
				if (cnt == 8) end_byte();
			end else begin
				miso_out = sh[7];
			end
		end
	end
	// master: one byte per go pulse; clock stands still between frames
	always @(posedge go) begin
		if (is_master && ss_n) begin
			flag = 1'b0;
			sh = tx_byte;
			sck_r = cpol;
			busy = 1'b1;
			for (int i = 0; i < 8; i++) begin
				if (!cpha) mosi_out = sh[7];
				#(HALF_NS) sck_r = !cpol;
				if (cpha) mosi_out = sh[7];
				else sh = {sh[6:0], miso_in};
				#(HALF_NS) sck_r = cpol;
				if (cpha) sh = {sh[6:0], miso_in};
			end
			#(HALF_NS) end_byte();
			busy = 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> ssp_host_tb.sv
// self-checking bench for the serial port host controller
// assumes the port model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module ssp_host_tb;
	// one transfer: port role, timing mode and both bytes
	typedef struct packed {
		logic port_master;
		logic cpol;
		logic cpha;
		logic [7:0] host_byte;
		logic [7:0] port_byte;
	} ssp_row_s;
	localparam ssp_row_s ROWS [8] = '{'{0, 0, 0, 8'h81, 8'h7e}, '{0, 0, 1, 8'hc3, 8'h18},
		'{0, 1, 0, 8'h5a, 8'h96}, '{0, 1, 1, 8'h01, 8'h80}, '{1, 0, 0, 8'he7, 8'h42},
		'{1, 0, 1, 8'h69, 8'hbd}, '{1, 1, 0, 8'h2d, 8'hf0}, '{1, 1, 1, 8'hff, 8'h00}};
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
	logic p_master = 1'b0, p_cpol = 1'b0, p_cpha = 1'b0, p_go = 1'b0;
	logic [7:0] p_tx = 8'h00;
	wire p_sck, p_sck_oe, p_mosi, p_mosi_oe, p_miso, p_miso_oe, p_busy;
	wire [7:0] p_rx;
	logic junk = 1'b0; // undriven lines wander instead of holding
	int fails = 0;
	int tests_run = 0;
	// resolved lines; the clock line is pulled to the polarity level
	wire sck_w = sck_oe ? sck_o : (p_sck_oe ? p_sck : p_cpol);
	wire mosi_w = mosi_oe ? mosi_o : (p_mosi_oe ? p_mosi : junk);
	wire miso_w = miso_oe ? miso_o : (p_miso_oe ? p_miso : junk);
	ssp_host uut (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
		.mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
		.miso_o(miso_o), .miso_oe(miso_oe), .ss_o(ss_o), .ss_oe(ss_oe));
	ssp_port_model port (.is_master(p_master), .cpol(p_cpol), .cpha(p_cpha),
		.tx_byte(p_tx), .go(p_go), .ss_n(ss_o), .sck_in(sck_w), .mosi_in(mosi_w),
		.miso_in(miso_w), .sck_out(p_sck), .sck_drv(p_sck_oe), .mosi_out(p_mosi),
		.mosi_drv(p_mosi_oe), .miso_out(p_miso), .miso_drv(p_miso_oe), .busy(p_busy),
		.rx_byte(p_rx));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) junk <= ~junk;
	task automatic final_report();
		if (fails == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	task automatic timeout();
		$display("Error wait expected answer seen none");
		fails++;
		final_report();
	endtask
	// one write; address and data offered together, each released when taken
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 100) timeout();
	endtask
	task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 100) timeout();
	endtask
	task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(what, exp, d);
		chk({what, " resp"}, {30'h0, er}, {30'h0, r});
	endtask
	// poll status until the engine has let go
	task automatic wait_idle();
		logic [31:0] d;
		logic [1:0] r;
		int n;
		for (n = 0; n < 60; n++) begin
			axi_rd(ssp_pkg::OFF_STATUS, d, r);
			if (d[ssp_pkg::ST_BUSY] === 1'b0) break;
		end
		if (n == 60) timeout();
	endtask
	task automatic do_reset();
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		chk("reset pins", {23'h0, ss_o, ss_oe, sck_oe, mosi_oe, miso_oe, awready, arready,
			bvalid, rvalid}, 32'h180);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd_chk("ctrl reset", ssp_pkg::OFF_CTRL, 32'h400, ssp_pkg::RESP_OKAY);
		rd_chk("gap reset", ssp_pkg::OFF_GAP, 32'h10, ssp_pkg::RESP_OKAY);
	endtask
	// set the mode while disabled, then enable and move one byte each way
	task automatic run_row(input ssp_row_s w, input logic [7:0] tx2);
		logic [31:0] c;
		logic [1:0] r;
		int n;
		c = {16'h0, 8'h04, 4'h0, w.cpha, w.cpol, !w.port_master, 1'b0};
		p_master <= w.port_master;
		p_cpol <= w.cpol;
		p_cpha <= w.cpha;
		p_tx <= w.port_byte;
		axi_wr(ssp_pkg::OFF_CTRL, c, r);
		axi_wr(ssp_pkg::OFF_CTRL, c | 32'h1, r);
		axi_wr(ssp_pkg::OFF_TX, {24'h0, w.host_byte}, r);
		if (tx2 != 8'h00) axi_wr(ssp_pkg::OFF_TX, {24'h0, tx2}, r);
		if (w.port_master) begin
			p_go <= 1'b1;
			@(posedge sys_clk);
			p_go <= 1'b0;
			for (n = 0; n < 200 && p_busy !== 1'b0; n++) @(posedge sys_clk);
			if (n == 200) timeout();
		end
		wait_idle();
		rd_chk("status", ssp_pkg::OFF_STATUS, {29'h0, tx2 != 8'h00, 2'b10},
			ssp_pkg::RESP_OKAY);
		rd_chk("rx", ssp_pkg::OFF_RX, {24'h0, w.port_byte}, ssp_pkg::RESP_OKAY);
		chk("port rx", {24'h0, w.host_byte}, {24'h0, p_rx});
		axi_wr(ssp_pkg::OFF_STATUS, 32'h6, r);
	endtask
	initial begin
		logic [1:0] r;
		do_reset();
		for (int i = 0; i < 8; i++) run_row(ROWS[i], 8'h00);
		run_row(ROWS[2], 8'h11);
		rd_chk("status clear", ssp_pkg::OFF_STATUS, 32'h0, ssp_pkg::RESP_OKAY);
		axi_wr(ssp_pkg::OFF_CTRL, 32'h0000ab0c, r);
		rd_chk("ctrl", ssp_pkg::OFF_CTRL, 32'h0000ab0c, ssp_pkg::RESP_OKAY);
		axi_wr(ssp_pkg::OFF_TX, 32'h55, r);
		rd_chk("idle write", ssp_pkg::OFF_STATUS, 32'h4, ssp_pkg::RESP_OKAY);
		axi_wr(ssp_pkg::OFF_GAP, 32'h3, r);
		rd_chk("gap", ssp_pkg::OFF_GAP, 32'h3, ssp_pkg::RESP_OKAY);
		axi_wr(6'h14, 32'hffffffff, r);
		chk("unmapped write", {30'h0, ssp_pkg::RESP_SLVERR}, {30'h0, r});
		rd_chk("unmapped", 6'h14, 32'h0, ssp_pkg::RESP_SLVERR);
		chk("port overrun", 32'h0, {31'h0, port.overrun_flag});
		do_reset();
		final_report();
	end
endmodule
`default_nettype wire
